// ==== rtl/wiper_host.sv ====
// host controller that drives select, step strobe and direction pins of the resistor
`timescale 1ns/1ns
module wiper_host #(
    parameter int DESEL_STORE_CYC = wiper_host_pkg::CYC_DESEL_STORE
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic [4:0] CMD_STEPS,
    input wire logic CMD_UP,
    input wire logic CMD_STORE,
    output logic SEL_N,
    output logic STEP_N,
    output logic DIR_UP,
    output logic BUSY,
    output logic [4:0] POS_EST
);
    wiper_host_pkg::state_t st_q, st_d;
    logic [19:0] cnt_q, cnt_d;
    logic [4:0] left_q, left_d;
    logic up_q, up_d;
    logic store_q, store_d;
    logic sel_n_q, sel_n_d;
    logic step_n_q, step_n_d;
    logic dir_q, dir_d;
    logic [4:0] pos_q, pos_d;
    logic cnt_zero;
    // strobe pulses put on the pin in one selection, held against the request
    logic [5:0] pulses_q, pulses_d;
    logic [4:0] asked_q, asked_d;

    assign cnt_zero = (cnt_q == 20'h00000);
    assign CMD_READY = (st_q == wiper_host_pkg::ST_IDLE) && cnt_zero;
    assign BUSY = !CMD_READY;
    assign SEL_N = sel_n_q;
    assign STEP_N = step_n_q;
    assign DIR_UP = dir_q;
    assign POS_EST = pos_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_zero ? cnt_q : cnt_q - 20'h00001;
        left_d = left_q;
        up_d = up_q;
        store_d = store_q;
        sel_n_d = sel_n_q;
        step_n_d = step_n_q;
        dir_d = dir_q;
        pos_d = pos_q;
        case (st_q)
            wiper_host_pkg::ST_IDLE: begin
                // strobe is high before select falls, so selecting never steps
                if (CMD_VALID && cnt_zero) begin
                    if (CMD_STEPS == 5'h00 && !CMD_STORE) begin
                        // nothing to move, and a bare deselect would store: stay off
                        cnt_d = 20'(wiper_host_pkg::CYC_DESEL_NOSTORE);
                    end else begin
                        left_d = CMD_STEPS;
                        up_d = CMD_UP;
                        store_d = CMD_STORE;
                        dir_d = CMD_UP;
                        sel_n_d = 1'b0;
                        cnt_d = 20'(wiper_host_pkg::CYC_SEL_SETUP);
                        st_d = wiper_host_pkg::ST_SEL;
                    end
                end
            end
            wiper_host_pkg::ST_SEL: begin
                if (cnt_zero) begin
                    if (left_q == 5'h00) begin
                        cnt_d = 20'(wiper_host_pkg::CYC_STEP_TO_DESEL);
                        st_d = wiper_host_pkg::ST_TAIL;
                    end else begin
                        step_n_d = 1'b0;
                        cnt_d = 20'(wiper_host_pkg::CYC_STEP_LOW);
                        st_d = wiper_host_pkg::ST_LOW;
                    end
                end
            end
            wiper_host_pkg::ST_LOW: begin
                if (cnt_zero) begin
                    left_d = left_q - 5'h01;
                    // mirror of the device counter, saturating like it
                    if (up_q && pos_q != wiper_host_pkg::POS_MAX) begin
                        pos_d = pos_q + 5'h01;
                    end else if (!up_q && pos_q != wiper_host_pkg::POS_MIN) begin
                        pos_d = pos_q - 5'h01;
                    end
                    if (left_q == 5'h01 && !store_q) begin
                        // last pulse of a no-store move: the strobe stays low through
                        // deselect, so the device does not store its count
                        cnt_d = 20'(wiper_host_pkg::CYC_STEP_TO_DESEL);
                        st_d = wiper_host_pkg::ST_TAIL;
                    end else begin
                        step_n_d = 1'b1;
                        cnt_d = 20'(wiper_host_pkg::CYC_STEP_HIGH);
                        st_d = wiper_host_pkg::ST_HIGH;
                    end
                end
            end
            wiper_host_pkg::ST_HIGH: begin
                if (cnt_zero) begin
                    if (left_q == 5'h00) begin
                        // only a storing move gets here: strobe stays high for deselect
                        cnt_d = 20'(wiper_host_pkg::CYC_STEP_TO_DESEL);
                        st_d = wiper_host_pkg::ST_TAIL;
                    end else begin
                        step_n_d = 1'b0;
                        cnt_d = 20'(wiper_host_pkg::CYC_STEP_LOW);
                        st_d = wiper_host_pkg::ST_LOW;
                    end
                end
            end
            wiper_host_pkg::ST_TAIL: begin
                if (cnt_zero) begin
                    sel_n_d = 1'b1;
                    st_d = wiper_host_pkg::ST_DESEL;
                    if (store_q) begin
                        cnt_d = 20'(DESEL_STORE_CYC);
                    end else begin
                        cnt_d = 20'(wiper_host_pkg::CYC_SETTLE);
                    end
                end
            end
            wiper_host_pkg::ST_DESEL: begin
                // strobe returns high only after select is high: no step
                step_n_d = 1'b1;
                st_d = wiper_host_pkg::ST_IDLE;
            end
            default: begin
                st_d = wiper_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_q <= wiper_host_pkg::ST_IDLE;
            // device recalls its stored count, unknown here; wait one settle
            cnt_q <= 20'(wiper_host_pkg::CYC_SETTLE);
            left_q <= 5'h00;
            up_q <= 1'b0;
            store_q <= 1'b0;
            sel_n_q <= 1'b1;
            step_n_q <= 1'b1;
            dir_q <= 1'b0;
            pos_q <= 5'h00;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            left_q <= left_d;
            up_q <= up_d;
            store_q <= store_d;
            sel_n_q <= sel_n_d;
            step_n_q <= step_n_d;
            dir_q <= dir_d;
            pos_q <= pos_d;
        end
    end

    always_comb begin
        pulses_d = pulses_q;
        asked_d = asked_q;
        if (CMD_VALID && CMD_READY) begin
            pulses_d = 6'h00;
            asked_d = CMD_STEPS;
        end else if (step_n_q && !step_n_d) begin
            pulses_d = pulses_q + 6'h01;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pulses_q <= 6'h00;
            asked_q <= 5'h00;
        end else begin
            pulses_q <= pulses_d;
            asked_q <= asked_d;
        end
    end

    sel_low_no_step_a: assert property (@(posedge CLK) disable iff (RESET)
        $fell(sel_n_q) |-> step_n_q) else $error("selected with strobe low");
    store_hold_a: assert property (@(posedge CLK) disable iff (RESET)
        ($rose(sel_n_q) && step_n_q) |=> BUSY [*8]) else $error("ready during store");
    dir_stable_a: assert property (@(posedge CLK) disable iff (RESET)
        $fell(step_n_q) |-> $stable(dir_q)) else $error("direction moved at strobe");
    step_low_len_a: assert property (@(posedge CLK) disable iff (RESET)
        $fell(step_n_q) && !sel_n_q |=> !step_n_q [*8]) else $error("strobe low too short");
    steps_selected_a: assert property (@(posedge CLK) disable iff (RESET)
        $fell(step_n_q) |-> !sel_n_q) else $error("strobe fell while deselected");
    sat_top_a: assert property (@(posedge CLK) disable iff (RESET)
        ($past(pos_q) == 5'h1f && $past(up_q)) |-> pos_q == 5'h1f) else $error("wrapped");
    nostore_low_a: assert property (@(posedge CLK) disable iff (RESET)
        ($rose(sel_n_q) && !store_q) |-> !step_n_q) else $error("store not skipped");
    desel_store_a: assert property (@(posedge CLK) disable iff (RESET)
        ($rose(sel_n_q) && store_q) |-> step_n_q) else $error("store not made");
    cover_store_c: cover property (@(posedge CLK) $rose(sel_n_q) && step_n_q);
    cover_nostore_c: cover property (@(posedge CLK) $rose(sel_n_q) && !step_n_q);
    cover_top_c: cover property (@(posedge CLK) pos_q == 5'h1f);
    sel_setup_a: assert property (@(posedge CLK) disable iff (RESET)
        $fell(sel_n_q) |=> step_n_q [*8]) else $error("strobe too soon after select");
    step_high_len_a: assert property (@(posedge CLK) disable iff (RESET)
        $rose(step_n_q) && !sel_n_q |=> step_n_q [*8]) else $error("strobe high too short");
    pulse_count_a: assert property (@(posedge CLK) disable iff (RESET)
        $rose(sel_n_q) |-> pulses_q == {1'b0, asked_q}) else $error("wrong pulse count");
    pos_step_a: assert property (@(posedge CLK) disable iff (RESET)
        $changed(pos_q) |-> (pos_q - $past(pos_q) == 5'h01) || ($past(pos_q) - pos_q == 5'h01))
        else $error("mirror moved more than one");
    sat_bottom_a: assert property (@(posedge CLK) disable iff (RESET)
        ($past(pos_q) == wiper_host_pkg::POS_MIN && !$past(up_q)) |-> pos_q == 5'h00)
        else $error("wrapped below bottom");
    nostore_settle_a: assert property (@(posedge CLK) disable iff (RESET)
        ($rose(sel_n_q) && !step_n_q) |=> BUSY [*8]) else $error("ready before settle");
    zero_skip_a: assert property (@(posedge CLK) disable iff (RESET)
        (CMD_VALID && CMD_READY && CMD_STEPS == 5'h00 && !CMD_STORE) |=> sel_n_q [*8])
        else $error("empty no-store move selected");
    ready_idle_a: assert property (@(posedge CLK) disable iff (RESET)
        CMD_READY |-> sel_n_q && step_n_q) else $error("ready while pins active");
    dir_idle_a: assert property (@(posedge CLK) disable iff (RESET)
        $changed(dir_q) |-> $fell(sel_n_q)) else $error("direction moved mid selection");
    cover_zero_c: cover property (@(posedge CLK) CMD_VALID && CMD_READY && CMD_STEPS == 5'h00);
    cover_bottom_c: cover property (@(posedge CLK) $fell(step_n_q) && !up_q && pos_q == 5'h00);
endmodule : wiper_host

// ==== rtl/wiper_host_pkg.sv ====
// constants for the host that steps and stores a digital resistor wiper
package wiper_host_pkg;
    localparam int CLK_MHZ = 100;
    localparam int POS_W = 5;
    localparam logic [4:0] POS_MAX = 5'h1f;
    localparam logic [4:0] POS_MIN = 5'h00;
    // minimum pin timings in ns
    localparam int T_SEL_SETUP_NS = 100;
    localparam int T_DIR_SETUP_NS = 100;
    localparam int T_DIR_HOLD_NS = 100;
    localparam int T_STEP_LOW_NS = 1000;
    localparam int T_STEP_HIGH_NS = 1000;
    localparam int T_STEP_TO_DESEL_NS = 1000;
    localparam int T_DESEL_NOSTORE_NS = 250;
    localparam int T_DESEL_STORE_NS = 10000000;
    localparam int T_SETTLE_NS = 10000;
    localparam int CYC_SEL_SETUP = (T_SEL_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_DIR_SETUP = (T_DIR_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_DIR_HOLD = (T_DIR_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_STEP_LOW = (T_STEP_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_STEP_HIGH = (T_STEP_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_STEP_TO_DESEL = (T_STEP_TO_DESEL_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_DESEL_NOSTORE = (T_DESEL_NOSTORE_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_DESEL_STORE = (T_DESEL_STORE_NS * CLK_MHZ + 999) / 1000;
    localparam int CYC_SETTLE = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 20;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SEL = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_TAIL = 3'b100,
        ST_DESEL = 3'b101
    } state_t;
endpackage : wiper_host_pkg

// ==== tb/wiper_dev_model.sv ====
// behavioural model of the stepped resistor driven by the host
`timescale 1ns/1ns
module wiper_dev_model (
    input wire logic pwr_on,
    input wire logic sel_n,
    input wire logic step_n,
    input wire logic dir_up,
    output logic [4:0] count_q,
    output logic [4:0] nv_q,
    output logic [31:0] tap
);
    initial count_q = 5'h00;
    initial nv_q = 5'h00;
    // recall only; nv keeps its value while power is off
    always @(posedge pwr_on) count_q = nv_q;
    always @(negedge step_n) begin
        if (pwr_on && !sel_n) begin
            if (dir_up && count_q != 5'h1f) count_q = count_q + 5'h01;
            else if (!dir_up && count_q != 5'h00) count_q = count_q - 5'h01;
        end
    end
    // standby after the store is implied: nothing moves until reselected
    always @(posedge sel_n) if (pwr_on && step_n) nv_q = count_q;
    assign tap = 32'h1 << count_q;
endmodule : wiper_dev_model

// ==== tb/wiper_host_tb_top.sv ====
// self-checking bench: host steps a modelled resistor, notes expected counts
`timescale 1ns/1ns
module wiper_host_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic [4:0] cmd_steps = 5'h00;
    logic cmd_up = 1'b0;
    logic cmd_store = 1'b0;
    logic pwr_on = 1'b1;
    logic cmd_ready, sel_n, step_n, dir_up, busy;
    logic busy_q = 1'b1;
    logic [4:0] pos_est, dev_cnt, dev_nv;
    logic [31:0] dev_tap;
    logic pending = 1'b0;
    logic [4:0] e_dev = 5'h00, e_pos = 5'h00, e_nv = 5'h00;
    logic [14:0] note;
    logic [14:0] notes[$];
    int fails = 0, checks = 0, cycles = 0;
    initial forever #5 clk = ~clk;
    wiper_host #(.DESEL_STORE_CYC(50)) uut (.CLK(clk), .RESET(reset), .CMD_VALID(cmd_valid),
        .CMD_READY(cmd_ready), .CMD_STEPS(cmd_steps), .CMD_UP(cmd_up), .CMD_STORE(cmd_store),
        .SEL_N(sel_n), .STEP_N(step_n), .DIR_UP(dir_up), .BUSY(busy), .POS_EST(pos_est));
    wiper_dev_model dev (.pwr_on(pwr_on), .sel_n(sel_n), .step_n(step_n), .dir_up(dir_up),
        .count_q(dev_cnt), .nv_q(dev_nv), .tap(dev_tap));
    function automatic logic [4:0] move(input logic [4:0] v, input int n, input logic up);
        int r;
        r = up ? int'(v) + n : int'(v) - n;
        if (r > 31) r = 31;
        if (r < 0) r = 0;
        return r[4:0];
    endfunction : move
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic send(input logic [4:0] n, input logic up, input logic st);
        while (cmd_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        e_pos = move(e_pos, n, up);
        e_dev = move(e_dev, n, up);
        if (st) e_nv = e_dev;
        notes.push_back({e_dev, e_pos, e_nv});
        cmd_valid = 1'b1;
        cmd_steps = n;
        cmd_up = up;
        cmd_store = st;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : send
    always @(posedge clk) begin
        busy_q <= busy;
        cycles++;
        // busy also falls after reset settles; only a taken command ends one
        if (pending && busy_q === 1'b1 && busy === 1'b0 && notes.size() > 0) begin
            pending <= 1'b0;
            note = notes.pop_front();
            chk(dev_cnt, note[14:10]);
            chk(pos_est, note[9:5]);
            chk(dev_nv, note[4:0]);
            chk({4'h0, dev_tap[note[14:10]]}, 5'h01);
        end
        if (cmd_valid === 1'b1 && cmd_ready === 1'b1) pending <= 1'b1;
        if (cycles == 80000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h00d756b4));
        repeat (8) @(posedge clk);
        #1;
        chk({4'h0, sel_n}, 5'h01);
        chk({4'h0, step_n}, 5'h01);
        reset = 1'b0;
        send(5'h1f, 1'b1, 1'b1);
        send(5'h03, 1'b1, 1'b0);
        send(5'h00, 1'b1, 1'b0);
        send(5'h00, 1'b0, 1'b1);
        send(5'h1f, 1'b0, 1'b0);
        for (int i = 0; i < 6; i++) send(5'($urandom_range(31)), 1'($urandom), 1'($urandom));
        while (notes.size() > 0) @(posedge clk);
        $display("test stepping done");
        #1;
        pwr_on = 1'b0;
        reset = 1'b1;
        e_dev = e_nv;
        e_pos = 5'h00;
        repeat (8) @(posedge clk);
        #1;
        chk({4'h0, sel_n}, 5'h01);
        pwr_on = 1'b1;
        reset = 1'b0;
        send(5'h02, 1'b1, 1'b1);
        while (notes.size() > 0) @(posedge clk);
        $display("test recall done");
        print_verdict();
    end
endmodule : wiper_host_tb_top
